// *** hdl/adc_clock_divider.sv ***
// Master clock and converter clock tick generation from the system clock
`timescale 1ns/100ps
`default_nettype none
module adc_clock_divider (
  input wire logic clk_in, // System clock
  input wire logic rst_b_in, // Synchronous reset, active low
  input wire logic run_in, // Converter enabled
  input wire logic [4:0] master_div_in, // master_clock_divider field
  input wire logic [2:0] filter_sel_in, // filter_clock_select field
  input wire logic chop_single_in, // Chop factor one instead of two
  output logic master_tick_out, // One pulse per master clock period
  output logic conv_tick_out // One pulse per converter clock period
);
  logic [5:0] master_cnt_reg; // Master divider count
  logic [6:0] conv_cnt_reg; // Converter divider count
  logic [5:0] master_last; // Terminal master count
  logic [6:0] conv_last; // Terminal converter count
  logic master_hit; // Master period complete

  // Twice (div + 1) cycles, so the last count is 2*div + 1
  assign master_last = {master_div_in, 1'b1};
  assign master_hit = (master_div_in == adc_pkg::DIV_BYPASS) || (master_cnt_reg >= master_last);
  // Converter period is N times the chop factor in master periods
  assign conv_last = chop_single_in ? 7'({1'b0, adc_pkg::filter_n(filter_sel_in)} - 7'h01)
                                    : 7'({adc_pkg::filter_n(filter_sel_in), 1'b0} - 7'h01);

  // Master divider; counter parked while disabled to save power
  always_ff @(posedge clk_in) begin
    if (!rst_b_in || !run_in) begin
      master_cnt_reg <= 6'h00;
      master_tick_out <= 1'b0;
    end else if (master_hit) begin
      master_cnt_reg <= 6'h00;
      master_tick_out <= 1'b1;
    end else begin
      master_cnt_reg <= master_cnt_reg + 6'h01;
      master_tick_out <= 1'b0;
    end
  end

  // Converter divider counts master ticks
  always_ff @(posedge clk_in) begin
    if (!rst_b_in || !run_in) begin
      conv_cnt_reg <= 7'h00;
      conv_tick_out <= 1'b0;
    end else if (master_tick_out && conv_cnt_reg >= conv_last) begin
      conv_cnt_reg <= 7'h00;
      conv_tick_out <= 1'b1;
    end else if (master_tick_out) begin
      conv_cnt_reg <= conv_cnt_reg + 7'h01;
      conv_tick_out <= 1'b0;
    end else begin
      conv_tick_out <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// *** hdl/adc_control.sv ***
// Top of the delta-sigma converter control block with its Avalon-MM register slave
//
// Operation
// - Master clock is system clock over 2(div+1); 0x1F bypasses
// - Filter select divides master clock; 000b gives 30x2
// - Oversampling select picks bits per word; 001b=8192
// - Word rate is master over N, chop, OSR
// - Modulator bit stream feeds sinc decimator to 24 bits
// - Results signed 24-bit, 8388607 down to -8388608
// - Converter runs only with power-off and sleep cleared
// - Filter-reset low-high-low pulse clears the sinc filter
// - Interrupt needs global and converter enables both set
// - End-of-conversion flag in second control register falls
// - Latch bit high keeps three result bytes coherent
// - First valid result follows fourth completion after reset
//
// Local design decisions: the Avalon-MM interface to the registers and the placing of the registers.
`timescale 1ns/100ps
`default_nettype none
module adc_control (
  input wire logic clk_in, // System clock, 200 MHz
  input wire logic rst_b_in, // Synchronous reset, active low
  input wire logic [4:0] avs_address_in, // Avalon byte address
  input wire logic avs_read_in, // Avalon read request
  input wire logic avs_write_in, // Avalon write request
  input wire logic [31:0] avs_writedata_in, // Avalon write data
  output logic [31:0] avs_readdata_out, // Avalon read data
  output logic avs_waitrequest_out, // Avalon wait request
  input wire logic mod_bit_in, // Modulator 1-bit output
  output logic mod_sample_out, // Converter clock pulse to the modulator
  output logic converter_enable_out, // Analog converter on
  output logic irq_out // Converter interrupt request pulse
);
  adc_pkg::ctrl_s ctrl_reg; // Software control fields
  logic wait_reg; // Waitrequest state
  logic [31:0] readdata_reg; // Read data holding
  logic [23:0] result_word_reg; // Latest valid word
  logic [23:0] result_view_reg; // Word seen by the bus
  logic eoc_reg; // End-of-conversion flag, low means done
  logic irq_reg; // Interrupt pulse
  logic mod_sample_reg; // Modulator sample pulse copy
  logic enable_reg; // Converter enable copy
  logic [2:0] settle_cnt_reg; // Completions since filter reset
  logic bus_req; // Any request present
  logic bus_accept; // Request completes at this edge
  logic write_accept; // Write takes effect
  logic run; // Converter enabled
  logic filter_hold; // Filter held in reset
  logic settled; // Latency passed
  logic new_word; // Valid word enters the result
  logic master_tick; // Master clock pulse
  logic conv_tick; // Converter clock pulse
  logic word_valid; // Raw word from filter
  logic [23:0] word; // Raw filter word

  // Bus handshake terms
  assign bus_req = avs_read_in || avs_write_in;
  assign bus_accept = bus_req && !wait_reg;
  assign write_accept = bus_accept && avs_write_in;

  // Power-off and sleep must both be clear
  assign run = !ctrl_reg.converter_power_off && !ctrl_reg.converter_sleep;
  // Filter stays cleared while the reset bit is high or the converter is off
  assign filter_hold = !run || ctrl_reg.filter_reset_bit;
  assign settled = (settle_cnt_reg >= adc_pkg::LATENCY_WORDS);
  // The word that completes the latency is already the first valid one
  assign new_word = word_valid && (settled || settle_cnt_reg == adc_pkg::LATENCY_WORDS - 3'h1);

  // Clock chain from system clock down to the converter clock
  adc_clock_divider u_divider (
    .clk_in(clk_in),
    .rst_b_in(rst_b_in),
    .run_in(run),
    .master_div_in(ctrl_reg.master_clock_divider),
    .filter_sel_in(ctrl_reg.filter_clock_select),
    .chop_single_in(ctrl_reg.chop_single),
    .master_tick_out(master_tick),
    .conv_tick_out(conv_tick)
  );

  // Decimation filter on the modulator stream
  sinc3_decimator u_sinc (
    .clk_in(clk_in),
    .rst_b_in(rst_b_in),
    .clear_in(filter_hold),
    .sample_in(conv_tick),
    .bit_in(mod_bit_in),
    .osr_log2_in(adc_pkg::osr_log2(ctrl_reg.oversampling_select)),
    .word_valid_out(word_valid),
    .word_out(word)
  );

  // Read multiplexer; unmapped addresses read zero
  function automatic logic [31:0] read_mux(input logic [4:0] addr);
    logic [31:0] data;
    data = 32'h00000000;
    case (addr)
      adc_pkg::OFF_CLOCK_SELECT: begin
        data[adc_pkg::POS_MASTER_DIV +: 5] = ctrl_reg.master_clock_divider;
      end
      adc_pkg::OFF_CONTROL_FIRST: begin
        data[adc_pkg::POS_OSR_SEL +: 3] = ctrl_reg.oversampling_select;
        data[adc_pkg::POS_POWER_OFF] = ctrl_reg.converter_power_off;
        data[adc_pkg::POS_SLEEP] = ctrl_reg.converter_sleep;
        data[adc_pkg::POS_FILTER_RESET] = ctrl_reg.filter_reset_bit;
        data[adc_pkg::POS_RESULT_LATCH] = ctrl_reg.result_latch_bit;
      end
      adc_pkg::OFF_CONTROL_SECOND: begin
        data[adc_pkg::POS_FILTER_SEL +: 3] = ctrl_reg.filter_clock_select;
        data[adc_pkg::POS_CHOP_SINGLE] = ctrl_reg.chop_single;
        data[adc_pkg::POS_EOC] = eoc_reg;
        data[adc_pkg::POS_SETTLED] = settled;
      end
      adc_pkg::OFF_INT_ENABLE: begin
        data[adc_pkg::POS_ADC_INT_EN] = ctrl_reg.converter_interrupt_enable;
        data[adc_pkg::POS_GLOBAL_INT_EN] = ctrl_reg.global_interrupt_enable;
      end
      // Bytes come from the frozen view so the three reads match
      adc_pkg::OFF_RESULT_LOW: begin
        data[7:0] = result_view_reg[7:0];
      end
      adc_pkg::OFF_RESULT_MIDDLE: begin
        data[7:0] = result_view_reg[15:8];
      end
      adc_pkg::OFF_RESULT_HIGH: begin
        data[7:0] = result_view_reg[23:16];
      end
      default: begin
        data = 32'h00000000;
      end
    endcase
    read_mux = data;
  endfunction

  // Waitrequest drops for one cycle after any request is seen
  always_ff @(posedge clk_in) begin
    if (!rst_b_in) begin
      wait_reg <= 1'b1;
    end else if (bus_req && wait_reg) begin
      wait_reg <= 1'b0;
    end else begin
      wait_reg <= 1'b1;
    end
  end

  // Read data captured one cycle before the accept edge and then held
  always_ff @(posedge clk_in) begin
    if (!rst_b_in) begin
      readdata_reg <= 32'h00000000;
    end else if (avs_read_in && wait_reg) begin
      readdata_reg <= read_mux(avs_address_in);
    end
  end

  // Control register writes; reserved bits are dropped
  always_ff @(posedge clk_in) begin
    if (!rst_b_in) begin
      ctrl_reg.master_clock_divider <= adc_pkg::RST_MASTER_DIV;
      ctrl_reg.filter_clock_select <= adc_pkg::RST_FILTER_SEL;
      ctrl_reg.chop_single <= 1'b0;
      ctrl_reg.oversampling_select <= adc_pkg::RST_OSR_SEL;
      ctrl_reg.converter_power_off <= adc_pkg::RST_POWER_OFF;
      ctrl_reg.converter_sleep <= adc_pkg::RST_SLEEP;
      ctrl_reg.filter_reset_bit <= 1'b0;
      ctrl_reg.result_latch_bit <= 1'b0;
      ctrl_reg.converter_interrupt_enable <= 1'b0;
      ctrl_reg.global_interrupt_enable <= 1'b0;
    end else if (write_accept) begin
      case (avs_address_in)
        adc_pkg::OFF_CLOCK_SELECT: begin
          ctrl_reg.master_clock_divider <= avs_writedata_in[adc_pkg::POS_MASTER_DIV +: 5];
        end
        adc_pkg::OFF_CONTROL_FIRST: begin
          ctrl_reg.oversampling_select <= avs_writedata_in[adc_pkg::POS_OSR_SEL +: 3];
          ctrl_reg.converter_power_off <= avs_writedata_in[adc_pkg::POS_POWER_OFF];
          ctrl_reg.converter_sleep <= avs_writedata_in[adc_pkg::POS_SLEEP];
          ctrl_reg.filter_reset_bit <= avs_writedata_in[adc_pkg::POS_FILTER_RESET];
          ctrl_reg.result_latch_bit <= avs_writedata_in[adc_pkg::POS_RESULT_LATCH];
        end
        adc_pkg::OFF_CONTROL_SECOND: begin
          ctrl_reg.filter_clock_select <= avs_writedata_in[adc_pkg::POS_FILTER_SEL +: 3];
          ctrl_reg.chop_single <= avs_writedata_in[adc_pkg::POS_CHOP_SINGLE];
        end
        adc_pkg::OFF_INT_ENABLE: begin
          ctrl_reg.converter_interrupt_enable <= avs_writedata_in[adc_pkg::POS_ADC_INT_EN];
          ctrl_reg.global_interrupt_enable <= avs_writedata_in[adc_pkg::POS_GLOBAL_INT_EN];
        end
        default: begin
          // Writes to result bytes and unmapped words are ignored
        end
      endcase
    end
  end

  // Latency counter restarts with every filter reset
  always_ff @(posedge clk_in) begin
    if (!rst_b_in || filter_hold) begin
      settle_cnt_reg <= 3'h0;
    end else if (word_valid && !settled) begin
      settle_cnt_reg <= settle_cnt_reg + 3'h1;
    end
  end

  // Latest valid word; the first three after reset are discarded
  always_ff @(posedge clk_in) begin
    if (!rst_b_in) begin
      result_word_reg <= 24'h000000;
    end else if (new_word) begin
      result_word_reg <= word;
    end
  end

  // Bus view follows the latest word only while the latch bit is low
  always_ff @(posedge clk_in) begin
    if (!rst_b_in) begin
      result_view_reg <= 24'h000000;
    end else if (!ctrl_reg.result_latch_bit) begin
      result_view_reg <= result_word_reg;
    end
  end

  // End-of-conversion flag; a completion beats a new period in the same cycle
  always_ff @(posedge clk_in) begin
    if (!rst_b_in || filter_hold) begin
      eoc_reg <= 1'b1;
    end else if (new_word) begin
      eoc_reg <= 1'b0;
    end else if (conv_tick) begin
      eoc_reg <= 1'b1;
    end
  end

  // Interrupt pulse as the flag falls, gated by both enables
  always_ff @(posedge clk_in) begin
    if (!rst_b_in) begin
      irq_reg <= 1'b0;
    end else begin
      irq_reg <= new_word && !filter_hold && ctrl_reg.converter_interrupt_enable
                 && ctrl_reg.global_interrupt_enable;
    end
  end

  // Registered copies to the analog side
  always_ff @(posedge clk_in) begin
    if (!rst_b_in) begin
      mod_sample_reg <= 1'b0;
      enable_reg <= 1'b0;
    end else begin
      mod_sample_reg <= conv_tick;
      enable_reg <= run;
    end
  end

  // Master tick is used only inside the divider chain
  assign avs_readdata_out = readdata_reg;
  assign avs_waitrequest_out = wait_reg;
  assign mod_sample_out = mod_sample_reg;
  assign converter_enable_out = enable_reg;
  assign irq_out = irq_reg;
endmodule
`default_nettype wire

// *** hdl/adc_pkg.sv ***
// Shared constants, field layouts and carrier types for the delta-sigma converter control block
package adc_pkg;
  // Register byte offsets on the Avalon slave
  localparam logic [4:0] OFF_CLOCK_SELECT = 5'h00;
  localparam logic [4:0] OFF_CONTROL_FIRST = 5'h04;
  localparam logic [4:0] OFF_CONTROL_SECOND = 5'h08;
  localparam logic [4:0] OFF_INT_ENABLE = 5'h0C;
  localparam logic [4:0] OFF_RESULT_LOW = 5'h10;
  localparam logic [4:0] OFF_RESULT_MIDDLE = 5'h14;
  localparam logic [4:0] OFF_RESULT_HIGH = 5'h18;
  // Field positions, clock_select_register
  localparam int POS_MASTER_DIV = 0;
  // Field positions, converter_control_first
  localparam int POS_OSR_SEL = 0;
  localparam int POS_POWER_OFF = 4;
  localparam int POS_SLEEP = 5;
  localparam int POS_FILTER_RESET = 6;
  localparam int POS_RESULT_LATCH = 7;
  // Field positions, converter_control_second
  localparam int POS_FILTER_SEL = 0;
  localparam int POS_CHOP_SINGLE = 3;
  localparam int POS_EOC = 4;
  localparam int POS_SETTLED = 5;
  // Field positions, interrupt enable register
  localparam int POS_ADC_INT_EN = 0;
  localparam int POS_GLOBAL_INT_EN = 1;
  // Reset values
  localparam logic [4:0] RST_MASTER_DIV = 5'h1F;
  localparam logic [2:0] RST_FILTER_SEL = 3'h0;
  localparam logic [2:0] RST_OSR_SEL = 3'h1;
  localparam logic RST_POWER_OFF = 1'b1;
  localparam logic RST_SLEEP = 1'b0;
  // Divider code that bypasses the master divider
  localparam logic [4:0] DIV_BYPASS = 5'h1F;
  // Filter divisor N per filter_clock_select code
  localparam logic [5:0] FILTER_N_CODE0 = 6'h1E;
  localparam logic [5:0] FILTER_N_CODE1 = 6'h18;
  localparam logic [5:0] FILTER_N_CODE2 = 6'h14;
  localparam logic [5:0] FILTER_N_CODE3 = 6'h10;
  localparam logic [5:0] FILTER_N_CODE4 = 6'h0C;
  localparam logic [5:0] FILTER_N_CODE5 = 6'h08;
  localparam logic [5:0] FILTER_N_CODE6 = 6'h04;
  localparam logic [5:0] FILTER_N_CODE7 = 6'h02;
  // Largest oversampling exponent, code 000b; code 001b gives 8192
  localparam logic [3:0] OSR_LOG2_MAX = 4'hE;
  // Completed words after a filter reset up to and including the first one that counts
  localparam logic [2:0] LATENCY_WORDS = 3'h4;
  // Output word bounds
  localparam logic [5:0] RESULT_MSB_POS = 6'h17;
  localparam logic signed [47:0] RESULT_MAX = 48'sh0000007FFFFF;
  localparam logic signed [47:0] RESULT_MIN = -48'sh000000800000;

  // Software controls as one carrier
  typedef struct packed {
    logic [4:0] master_clock_divider;
    logic [2:0] filter_clock_select;
    logic chop_single;
    logic [2:0] oversampling_select;
    logic converter_power_off;
    logic converter_sleep;
    logic filter_reset_bit;
    logic result_latch_bit;
    logic converter_interrupt_enable;
    logic global_interrupt_enable;
  } ctrl_s;

  // Divisor N for a filter_clock_select code
  function automatic logic [5:0] filter_n(input logic [2:0] sel);
    case (sel)
      3'h0: filter_n = FILTER_N_CODE0;
      3'h1: filter_n = FILTER_N_CODE1;
      3'h2: filter_n = FILTER_N_CODE2;
      3'h3: filter_n = FILTER_N_CODE3;
      3'h4: filter_n = FILTER_N_CODE4;
      3'h5: filter_n = FILTER_N_CODE5;
      3'h6: filter_n = FILTER_N_CODE6;
      default: filter_n = FILTER_N_CODE7;
    endcase
  endfunction

  // Oversampling exponent for an oversampling_select code
  function automatic logic [3:0] osr_log2(input logic [2:0] sel);
    osr_log2 = OSR_LOG2_MAX - {1'b0, sel};
  endfunction
endpackage

// *** hdl/sinc3_decimator.sv ***
// Third-order sinc decimator turning the 1-bit modulator stream into 24-bit words
`timescale 1ns/100ps
`default_nettype none
module sinc3_decimator (
  input wire logic clk_in, // System clock
  input wire logic rst_b_in, // Synchronous reset, active low
  input wire logic clear_in, // Filter state reset
  input wire logic sample_in, // Take one modulator bit
  input wire logic bit_in, // Modulator output bit
  input wire logic [3:0] osr_log2_in, // Oversampling exponent
  output logic word_valid_out, // One-cycle pulse with a new word
  output logic [23:0] word_out // Signed two's complement word
);
  logic signed [47:0] int1_reg, int2_reg, int3_reg; // Integrator chain
  logic signed [47:0] dly1_reg, dly2_reg, dly3_reg; // Comb delays
  logic signed [47:0] comb1, comb2, comb3, scaled, in_val; // Comb path
  logic [13:0] dec_cnt_reg; // Decimation count
  logic [13:0] dec_last; // Last bit of one output word
  logic [5:0] gain_log2; // Filter gain exponent, three times OSR exponent
  logic dec_hit; // Word boundary

  // Bit one is plus one, bit zero is minus one
  assign in_val = bit_in ? 48'sh000000000001 : -48'sh000000000001;
  assign dec_last = ~(14'h3FFF << osr_log2_in);
  assign dec_hit = sample_in && (dec_cnt_reg == dec_last);
  assign comb1 = int3_reg - dly1_reg;
  assign comb2 = comb1 - dly2_reg;
  assign comb3 = comb2 - dly3_reg;
  assign gain_log2 = 6'({osr_log2_in, 1'b0}) + {2'h0, osr_log2_in};

  // Normalise full scale to 2^23; from OSR exponent 8 upward the gain exceeds it
  always_comb begin
    scaled = comb3;
    if (gain_log2 >= adc_pkg::RESULT_MSB_POS) begin
      scaled = comb3 >>> (gain_log2 - adc_pkg::RESULT_MSB_POS);
    end else begin
      scaled = comb3 <<< (adc_pkg::RESULT_MSB_POS - gain_log2);
    end
  end

  // Integrators run at the modulator bit rate
  always_ff @(posedge clk_in) begin
    if (!rst_b_in || clear_in) begin
      int1_reg <= 48'sh000000000000;
      int2_reg <= 48'sh000000000000;
      int3_reg <= 48'sh000000000000;
      dec_cnt_reg <= 14'h0000;
    end else if (sample_in) begin
      int1_reg <= int1_reg + in_val;
      int2_reg <= int2_reg + int1_reg;
      int3_reg <= int3_reg + int2_reg;
      dec_cnt_reg <= dec_hit ? 14'h0000 : dec_cnt_reg + 14'h0001;
    end
  end

  // Combs run once per word; all-ones input would overflow, so saturate
  always_ff @(posedge clk_in) begin
    if (!rst_b_in || clear_in) begin
      dly1_reg <= 48'sh000000000000;
      dly2_reg <= 48'sh000000000000;
      dly3_reg <= 48'sh000000000000;
      word_out <= 24'h000000;
      word_valid_out <= 1'b0;
    end else if (dec_hit) begin
      dly1_reg <= int3_reg;
      dly2_reg <= comb1;
      dly3_reg <= comb2;
      word_valid_out <= 1'b1;
      if (scaled > adc_pkg::RESULT_MAX) begin
        word_out <= 24'h7FFFFF;
      end else if (scaled < adc_pkg::RESULT_MIN) begin
        word_out <= 24'h800000;
      end else begin
        word_out <= scaled[23:0];
      end
    end else begin
      word_valid_out <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// *** test/adc_control_checker.sv ***
// Port-level assertions for the converter control block
`timescale 1ns/100ps
`default_nettype none
module adc_control_checker (
  input wire logic clk_in, // System clock
  input wire logic rst_b_in, // Reset, active low
  input wire logic avs_read_in, // Bus read
  input wire logic avs_write_in, // Bus write
  input wire logic [31:0] avs_readdata_out, // Read data
  input wire logic avs_waitrequest_out, // Wait request
  input wire logic mod_sample_out, // Converter pulse
  input wire logic converter_enable_out, // Converter on
  input wire logic irq_out // Interrupt pulse
);
  // One clock domain, so one default for all
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (!rst_b_in);
  // Exactly one wait cycle per request
  wait_one_a: assert property (
    (avs_read_in || avs_write_in) && avs_waitrequest_out |=> !avs_waitrequest_out) else $error("wait too long");
  // Wait low lasts one cycle
  wait_pulse_a: assert property (!avs_waitrequest_out |=> avs_waitrequest_out) else $error("wait low held");
  // Wait low only answers a request
  wait_cause_a: assert property (
    !avs_waitrequest_out |-> $past(avs_read_in) || $past(avs_write_in)) else $error("spurious answer");
  // Latched bus data move only on a read
  read_hold_a: assert property (!avs_read_in |=> $stable(avs_readdata_out)) else $error("readdata moved");
  // Outputs quiet right after reset; checked through reset itself
  reset_quiet_a: assert property (disable iff (1'b0) !rst_b_in |=> avs_waitrequest_out && !irq_out
    && !mod_sample_out && !converter_enable_out && avs_readdata_out == 32'h00000000) else $error("reset state");
  // Converter pulses never back to back
  sample_gap_a: assert property (mod_sample_out |=> !mod_sample_out) else $error("pulse too long");
  // Interrupt pulses at least nine system cycles apart
  irq_gap_a: assert property (irq_out |=> !irq_out [*8]) else $error("irq too close");
  // No converter pulse while switched off
  off_silent_a: assert property (
    !converter_enable_out && !$past(converter_enable_out) |-> !mod_sample_out) else $error("pulse while off");
endmodule
`default_nettype wire

// *** test/adc_control_tb.sv ***
// Self-checking bench for the converter control block
`timescale 1ns/100ps
`default_nettype none
module adc_control_tb;
  logic clk_in = 1'b0; // System clock, 5 ns
  logic rst_b_in = 1'b0; // Reset, active low
  logic [4:0] addr = 5'h00; // Bus address
  logic rd = 1'b0; // Bus read
  logic wr = 1'b0; // Bus write
  logic [31:0] wdata = 32'h00000000; // Bus write data
  logic [31:0] rdata; // Bus read data
  logic wreq; // Wait request
  logic level = 1'b1; // Modulator stream level
  logic mbit; // Modulator bit
  logic samp; // Converter pulse
  logic en; // Converter on
  logic irq; // Interrupt pulse
  logic [31:0] rv; // Last read value
  int c; // Cycles counted by a wait
  int err_total = 0; // Mismatches
  int checked = 0; // Comparisons
  // Free-running clock
  always #2.5 clk_in = !clk_in;
  adc_control u_adc_control (.clk_in(clk_in), .rst_b_in(rst_b_in), .avs_address_in(addr), .avs_read_in(rd),
    .avs_write_in(wr), .avs_writedata_in(wdata), .avs_readdata_out(rdata), .avs_waitrequest_out(wreq),
    .mod_bit_in(mbit), .mod_sample_out(samp), .converter_enable_out(en), .irq_out(irq));
  mod_model u_mod_model (.level_in(level), .bit_out(mbit));
  // Counts a comparison, reports a mismatch
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      err_total++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask
  // One access; waitrequest and read data taken at the same rising edge, then one idle edge
  task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d);
    int n;
    n = 0;
    addr <= a;
    wr <= w;
    rd <= !w;
    wdata <= d;
    do begin
      @(posedge clk_in);
      n++;
    end while (wreq !== 1'b0);
    rv = rdata;
    wr <= 1'b0;
    rd <= 1'b0;
    @(posedge clk_in);
    chk("wait_edges", 32'h2, n);
  endtask
  // Read and compare the masked value
  task automatic rd_chk(input string what, input logic [4:0] a, input logic [31:0] m, input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    chk(what, exp, rv & m);
  endtask
  // Cycles until the next converter pulse (sel) or interrupt, capped at lim
  task automatic wait_pulse(input logic sel, input int lim, output int n);
    n = 0;
    do begin
      @(negedge clk_in);
      n++;
    end while ((sel ? samp : irq) !== 1'b1 && n < lim);
    @(posedge clk_in);
  endtask
  // Register reset values and an unmapped place
  task automatic t_reset();
    rd_chk("div", 5'h00, 32'hFFFFFFFF, 32'h1F);
    rd_chk("ctrl1", 5'h04, 32'hFFFFFFFF, 32'h11);
    rd_chk("ctrl2", 5'h08, 32'hFFFFFFFF, 32'h10);
    rd_chk("inten", 5'h0C, 32'hFFFFFFFF, 32'h00);
    rd_chk("unmapped", 5'h1C, 32'hFFFFFFFF, 32'h00);
    chk("enable", 32'h0, {31'h0, en});
  endtask
  // Fast setup in order, filter pulse, first word after four periods
  task automatic t_first();
    bus(1'b1, 5'h00, 32'h1F);
    bus(1'b1, 5'h08, 32'h0F);
    bus(1'b1, 5'h04, 32'h07);
    bus(1'b1, 5'h0C, 32'h03);
    bus(1'b1, 5'h04, 32'h47);
    bus(1'b1, 5'h04, 32'h07);
    wait_pulse(1'b0, 2000, c);
    chk("first_word", 32'h1, {31'h0, c > 768 && c <= 1040});
    chk("enable", 32'h1, {31'h0, en});
    wait_pulse(1'b0, 2000, c);
    chk("word_gap", 32'h100, c);
    rd_chk("low", 5'h10, 32'hFF, 32'hFF);
    rd_chk("high", 5'h18, 32'hFF, 32'h7F);
  endtask
  // Latched bytes stay frozen while new words arrive
  task automatic t_latch();
    bus(1'b1, 5'h04, 32'h87);
    level <= 1'b0;
    repeat (5) wait_pulse(1'b0, 2000, c);
    rd_chk("low", 5'h10, 32'hFF, 32'hFF);
    rd_chk("middle", 5'h14, 32'hFF, 32'hFF);
    rd_chk("high", 5'h18, 32'hFF, 32'h7F);
    bus(1'b1, 5'h04, 32'h07);
    rd_chk("middle", 5'h14, 32'hFF, 32'h00);
    rd_chk("high", 5'h18, 32'hFF, 32'h80);
  endtask
  // Pulse spacing for bypass and two divider codes
  task automatic t_rate();
    for (int d = 0; d < 3; d++) begin
      bus(1'b1, 5'h00, (d == 2) ? 32'h1F : d);
      // First two pulses may still follow the old divider phase
      repeat (3) wait_pulse(1'b1, 200, c);
      chk("pulse_gap", (d == 2) ? 2 : 4 * (d + 1), c);
    end
  endtask
  // Interrupt only with both enables set
  task automatic t_mask();
    for (int m = 0; m < 4; m++) begin
      bus(1'b1, 5'h0C, m);
      wait_pulse(1'b0, 600, c);
      chk("irq_masked", (m == 3) ? 1 : 0, {31'h0, c < 600});
    end
  endtask
  // Slow clock of 30 times 2: EOC low after a word, high next period
  task automatic t_eoc();
    bus(1'b1, 5'h08, 32'h00);
    repeat (3) wait_pulse(1'b1, 200, c);
    chk("pulse_gap", 32'h3C, c);
    wait_pulse(1'b0, 20000, c);
    rd_chk("eoc_low", 5'h08, 32'h10, 32'h00);
    repeat (70) @(posedge clk_in);
    rd_chk("eoc_high", 5'h08, 32'h10, 32'h10);
  endtask
  // Sleep, then power-off: converter stops, EOC stays high
  task automatic t_off();
    for (int k = 0; k < 2; k++) begin
      bus(1'b1, 5'h04, k ? 32'h17 : 32'h27);
      repeat (3) @(posedge clk_in);
      wait_pulse(1'b1, 200, c);
      chk("pulses_off", 32'hC8, c);
      chk("enable", 32'h0, {31'h0, en});
      rd_chk("eoc_off", 5'h08, 32'h10, 32'h10);
    end
  endtask
  // Verdict and end of run
  task automatic print_verdict();
    if (err_total == 0 && checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  // Main sequence
  initial begin
    repeat (10) @(posedge clk_in);
    rst_b_in <= 1'b1;
    @(posedge clk_in);
    t_reset();
    t_first();
    t_latch();
    t_rate();
    t_mask();
    t_eoc();
    t_off();
    print_verdict();
  end
  // Watchdog, far past the expected 13000 cycles
  initial begin
    repeat (80000) @(posedge clk_in);
    err_total++;
    print_verdict();
  end
endmodule
bind adc_control adc_control_checker u_adc_control_checker (.clk_in, .rst_b_in, .avs_read_in, .avs_write_in,
  .avs_readdata_out, .avs_waitrequest_out, .mod_sample_out, .converter_enable_out, .irq_out);
`default_nettype wire

// *** test/mod_model.sv ***
// Modulator stand-in driving the 1-bit stream at a level the bench picks
`timescale 1ns/100ps
`default_nettype none
module mod_model (
  input wire logic level_in, // Stream level, all ones or all zeros
  output logic bit_out // Modulator bit
);
  // Constant stream, always a defined level on the line
  assign bit_out = level_in;
endmodule
`default_nettype wire
